// ===== rtl/blc_exec.sv
// Purpose: execution unit for carry-and-bit, compare-jump, clear, complement, decimal adjust
// Assumes: decoder presents opcode plus operand bytes with start_i; operands pre-fetched
// Notes:   bit writes go out as one-cycle strobes; the unit owns acc, carry and pc
`timescale 1ns/1ps
`default_nettype none
module blc_exec (
  input  wire logic        ref_clk_i,    // core clock
  input  wire logic        reset_n_i,    // async reset, active low
  input  wire logic        start_i,      // new instruction presented
  input  wire logic [7:0]  opcode_i,     // first instruction byte
  input  wire logic [7:0]  byte2_i,      // second byte (bit addr / direct / immediate)
  input  wire logic [7:0]  byte3_i,      // third byte (relative displacement)
  input  wire logic [7:0]  operand_i,    // fetched byte operand (direct, reg or indirect)
  input  wire logic        bit_val_i,    // addressed bit as read from memory or pin
  input  wire logic        bit_latch_i,  // addressed bit as held in port output latch
  input  wire logic        bit_is_port_i,// addressed bit lies in a port latch
  input  wire logic        aux_carry_i,  // auxiliary carry flag from status word
  output logic             busy_o,       // instruction in progress
  output logic             retire_o,     // one-cycle pulse: instruction done
  output logic [7:0]       acc_o,        // accumulator
  output logic             carry_o,      // carry flag
  output logic [15:0]      pc_o,         // program counter
  output logic             bit_wr_o,     // one-cycle bit write strobe
  output logic [7:0]       bit_addr_o,   // bit write address
  output logic             bit_data_o    // bit write value
);
  // ==========================================================
  // decode
  function automatic logic [2:0] cycles_of(input logic [7:0] op);
    logic [2:0] c;
    c = blc_pkg::CYC_ONE;
    if (op == blc_pkg::OPC_AND_C_BIT || op == blc_pkg::OPC_AND_C_NBIT ||
        op == blc_pkg::OPC_CLEAR_BIT || op == blc_pkg::OPC_INV_BIT)
      c = blc_pkg::CYC_TWO;
    if (op == blc_pkg::OPC_CMPJ_A_DIR || op == blc_pkg::OPC_CMPJ_A_IMM ||
        op == blc_pkg::OPC_CMPJ_IND0 || op == blc_pkg::OPC_CMPJ_IND1 ||
        op[7:3] == blc_pkg::OPC_CMPJ_REG_HI)
      c = blc_pkg::CYC_FOUR;
    return c;
  endfunction

  function automatic logic is_cmp_jump(input logic [7:0] op);
    return cycles_of(op) == blc_pkg::CYC_FOUR;
  endfunction

  blc_pkg::blc_state_t state_r;
  logic [2:0]  cnt_r;
  logic [7:0]  op_r;
  logic [7:0]  b2_r;
  logic [7:0]  b3_r;
  logic [7:0]  opnd_r;
  logic        bit_r;
  logic        latch_r;
  logic        port_r;
  logic        last_c;
  logic [7:0]  cmp_a;
  logic [7:0]  cmp_b;
  logic [7:0]  da_lo;
  logic        da_c1;
  logic [8:0]  da_sum1;
  logic [8:0]  da_sum2;
  logic        da_c2;

  // ==========================================================
  // sequencing: hold the instruction for its listed cycle count
  assign last_c   = (state_r == blc_pkg::ST_BUSY) && (cnt_r == blc_pkg::CYC_ONE);
  assign busy_o   = (state_r == blc_pkg::ST_BUSY);
  assign retire_o = last_c;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= blc_pkg::ST_IDLE;
      cnt_r   <= 3'h0;
    end else if (state_r != blc_pkg::ST_BUSY && start_i) begin
      state_r <= blc_pkg::ST_BUSY;
      cnt_r   <= cycles_of(opcode_i);
    end else if (last_c) begin
      state_r <= blc_pkg::ST_DONE;
      cnt_r   <= 3'h0;
    end else if (state_r == blc_pkg::ST_BUSY) begin
      cnt_r   <= cnt_r - 3'h1;
    end else begin
      state_r <= blc_pkg::ST_IDLE;
    end
  end

  // operands captured at start so they stay stable through the instruction
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_r    <= 8'h00;
      b2_r    <= 8'h00;
      b3_r    <= 8'h00;
      opnd_r  <= 8'h00;
      bit_r   <= 1'b0;
      latch_r <= 1'b0;
      port_r  <= 1'b0;
    end else if (state_r != blc_pkg::ST_BUSY && start_i) begin
      op_r    <= opcode_i;
      b2_r    <= byte2_i;
      b3_r    <= byte3_i;
      opnd_r  <= operand_i;
      bit_r   <= bit_val_i;
      latch_r <= bit_latch_i;
      port_r  <= bit_is_port_i;
    end
  end

  // ==========================================================
  // compare operands: accumulator forms versus register/indirect forms
  always_comb begin
    cmp_a = acc_o;
    cmp_b = operand_i;
    if (op_r == blc_pkg::OPC_CMPJ_A_DIR) begin
      cmp_a = acc_o;
      cmp_b = opnd_r;
    end else if (op_r == blc_pkg::OPC_CMPJ_A_IMM) begin
      cmp_a = acc_o;
      cmp_b = b2_r;
    end else begin
      cmp_a = opnd_r;
      cmp_b = b2_r;
    end
  end

  // ==========================================================
  // decimal adjust, addition correction only; other inputs give no defined meaning
  always_comb begin
    da_sum1 = {1'b0, acc_o};
    if (acc_o[3:0] > blc_pkg::BCD_MAX || aux_carry_i)
      da_sum1 = {1'b0, acc_o} + {5'h00, blc_pkg::BCD_FIX};
    da_lo = da_sum1[7:0];
    da_c1 = carry_o | da_sum1[8];
    da_sum2 = {1'b0, da_lo};
    if (da_c1 || da_lo[7:4] > blc_pkg::BCD_MAX)
      da_sum2 = {1'b0, da_lo} + {1'b0, blc_pkg::BCD_FIX, 4'h0};
    da_c2 = da_c1 | da_sum2[8];
  end

  // ==========================================================
  // accumulator; compare never writes it
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_o <= blc_pkg::ACC_RST;
    end else if (last_c) begin
      case (op_r)
        blc_pkg::OPC_CLEAR_A: acc_o <= 8'h00;
        blc_pkg::OPC_INV_A:   acc_o <= ~acc_o;
        blc_pkg::OPC_DECADJ:  acc_o <= da_sum2[7:0];
        default:            acc_o <= acc_o;
      endcase
    end
  end

  // carry; the only flag this unit owns, so overflow is never touched
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      carry_o <= 1'b0;
    end else if (last_c) begin
      if (is_cmp_jump(op_r)) begin
        carry_o <= (cmp_a < cmp_b);
      end else begin
        case (op_r)
          blc_pkg::OPC_AND_C_BIT:  carry_o <= carry_o & bit_r;
          blc_pkg::OPC_AND_C_NBIT: carry_o <= carry_o & ~bit_r;
          blc_pkg::OPC_CLEAR_C:    carry_o <= 1'b0;
          blc_pkg::OPC_INV_C:      carry_o <= ~carry_o;
          blc_pkg::OPC_DECADJ:     carry_o <= da_c2;
          default:                 carry_o <= carry_o;
        endcase
      end
    end
  end

  // program counter: compare adds length, then displacement when unequal
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_o <= blc_pkg::PC_RST;
    end else if (last_c && is_cmp_jump(op_r)) begin
      if (cmp_a != cmp_b)
        pc_o <= pc_o + blc_pkg::CMPJ_LEN + {{8{b3_r[7]}}, b3_r};
      else
        pc_o <= pc_o + blc_pkg::CMPJ_LEN;
    end
  end

  // bit write-back; complement of a port bit starts from the latch, not the pin
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_wr_o   <= 1'b0;
      bit_addr_o <= 8'h00;
      bit_data_o <= 1'b0;
    end else begin
      bit_wr_o <= 1'b0;
      if (last_c && op_r == blc_pkg::OPC_CLEAR_BIT) begin
        bit_wr_o   <= 1'b1;
        bit_addr_o <= b2_r;
        bit_data_o <= 1'b0;
      end else if (last_c && op_r == blc_pkg::OPC_INV_BIT) begin
        bit_wr_o   <= 1'b1;
        bit_addr_o <= b2_r;
        bit_data_o <= port_r ? ~latch_r : ~bit_r;
      end
    end
  end

  // ==========================================================
  // checks
  AST_CMPJ_FOUR: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start_i && !busy_o && is_cmp_jump(opcode_i)) |-> ##4 retire_o)
    else $error("compare-jump did not retire after four cycles");
  AST_TWO_CYC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start_i && !busy_o && opcode_i == blc_pkg::OPC_AND_C_BIT) |-> ##2 retire_o)
    else $error("carry-and-bit did not retire after two cycles");
  AST_ONE_CYC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start_i && !busy_o && opcode_i == blc_pkg::OPC_DECADJ) |-> ##1 retire_o)
    else $error("decimal adjust took more than one cycle");
  AST_AND_ZERO: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_AND_C_BIT && !bit_r) |=> !carry_o)
    else $error("carry not cleared by zero source bit");
  AST_AND_KEEP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_AND_C_BIT && bit_r) |=> $stable(carry_o))
    else $error("carry changed by a one source bit");
  AST_AND_NBIT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_AND_C_NBIT) |=>
      (carry_o == ($past(carry_o) & ~$past(bit_r))) && !bit_wr_o)
    else $error("complemented carry-and wrong or wrote the bit");
  AST_CMPJ_PC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && is_cmp_jump(op_r) && cmp_a == cmp_b) |=>
      pc_o == $past(pc_o) + blc_pkg::CMPJ_LEN)
    else $error("equal compare did not advance pc by three");
  AST_CMPJ_JUMP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && is_cmp_jump(op_r) && cmp_a != cmp_b) |=>
      pc_o == $past(pc_o) + blc_pkg::CMPJ_LEN + {{8{$past(b3_r[7])}}, $past(b3_r)})
    else $error("unequal compare did not take the displacement");
  AST_PC_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && !is_cmp_jump(op_r)) |=> $stable(pc_o))
    else $error("pc moved outside a compare");
  AST_CMPJ_C: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && is_cmp_jump(op_r)) |=> carry_o == ($past(cmp_a) < $past(cmp_b)))
    else $error("compare carry wrong");
  AST_CMPJ_ACC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && is_cmp_jump(op_r)) |=> $stable(acc_o) && !bit_wr_o)
    else $error("compare modified an operand");
  AST_CLEAR_A: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_CLEAR_A) |=> acc_o == 8'h00 && $stable(carry_o))
    else $error("clear accumulator wrong");
  AST_INV_A: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_INV_A) |=> acc_o == ~$past(acc_o) && $stable(carry_o))
    else $error("complement accumulator wrong");
  AST_INV_PORT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_INV_BIT && port_r) |=> bit_wr_o && bit_data_o == !latch_r)
    else $error("port complement not taken from latch");
  AST_DEC_CSET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_DECADJ && carry_o) |=> carry_o)
    else $error("decimal adjust cleared carry");
  AST_DEC_NONE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_DECADJ && !carry_o && !aux_carry_i &&
     acc_o[3:0] <= blc_pkg::BCD_MAX && acc_o[7:4] <= blc_pkg::BCD_MAX) |=>
      $stable(acc_o) && !carry_o)
    else $error("decimal adjust changed valid digits");
  AST_DEC_LOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_DECADJ && !carry_o && aux_carry_i &&
     acc_o[3:0] < blc_pkg::BCD_MAX && acc_o[7:4] < blc_pkg::BCD_MAX) |=>
      acc_o == $past(acc_o) + {4'h0, blc_pkg::BCD_FIX})
    else $error("decimal adjust missed the low nibble fix");
  AST_CLEAR_C: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_CLEAR_C) |=> !carry_o && $stable(acc_o))
    else $error("clear carry wrong");
  AST_CLEAR_BIT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_CLEAR_BIT) |=> bit_wr_o && !bit_data_o && $stable(carry_o))
    else $error("clear bit wrong");
  AST_INV_C: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_INV_C) |=> carry_o != $past(carry_o) && $stable(acc_o))
    else $error("complement carry wrong");
  AST_INV_BIT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (retire_o && op_r == blc_pkg::OPC_INV_BIT && !port_r) |=> bit_data_o == !bit_r)
    else $error("bit complement wrong");
  AST_BUSY_TAKE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start_i && !busy_o) |=> busy_o)
    else $error("instruction not taken");
  AST_RETIRE_PULSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    retire_o |=> !retire_o && !busy_o)
    else $error("retire longer than one cycle");
  AST_WR_PULSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    bit_wr_o |=> !bit_wr_o)
    else $error("bit write strobe longer than one cycle");
endmodule
`default_nettype wire

// ===== rtl/blc_pkg.sv
// Purpose: constants for the bit-logic / compare / decimal-adjust execution unit
// Assumes: 8-bit core, one machine cycle per ref_clk_i cycle
// Notes:   opcodes are the instruction encodings this unit executes
package blc_pkg;
  localparam logic [7:0] OPC_AND_C_BIT  = 8'h82;
  localparam logic [7:0] OPC_AND_C_NBIT = 8'hb0;
  localparam logic [7:0] OPC_CMPJ_A_DIR = 8'hb5;
  localparam logic [7:0] OPC_CMPJ_A_IMM = 8'hb4;
  localparam logic [7:0] OPC_CMPJ_IND0  = 8'hb6;
  localparam logic [7:0] OPC_CMPJ_IND1  = 8'hb7;
  localparam logic [4:0] OPC_CMPJ_REG_HI = 5'h17;
  localparam logic [7:0] OPC_CLEAR_A    = 8'he4;
  localparam logic [7:0] OPC_CLEAR_C    = 8'hc3;
  localparam logic [7:0] OPC_CLEAR_BIT  = 8'hc2;
  localparam logic [7:0] OPC_INV_A      = 8'hf4;
  localparam logic [7:0] OPC_INV_C      = 8'hb3;
  localparam logic [7:0] OPC_INV_BIT    = 8'hb2;
  localparam logic [7:0] OPC_DECADJ     = 8'hd4;
  localparam logic [2:0] CYC_ONE        = 3'h1;
  localparam logic [2:0] CYC_TWO        = 3'h2;
  localparam logic [2:0] CYC_FOUR       = 3'h4;
  localparam logic [15:0] CMPJ_LEN      = 16'h0003;
  localparam logic [3:0] BCD_MAX        = 4'h9;
  localparam logic [3:0] BCD_FIX        = 4'h6;
  localparam logic [7:0] ACC_RST        = 8'h00;
  localparam logic [15:0] PC_RST        = 16'h0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } blc_state_t;
endpackage

// ===== test/tb.sv
// Purpose: self-checking bench for the bit-logic / compare / decimal-adjust execution unit
// Assumes: one instruction at a time, operands held from the take edge until the next issue
// Notes:   the accumulator can only be reached through clear, complement and adjust,
//          so the scenarios chain those to build the values they need
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // stimulus and observation
  logic        ref_clk_i     = 1'b0;
  logic        reset_n_i     = 1'b0;
  logic        start_i       = 1'b0;
  logic [7:0]  opcode_i      = 8'h00;
  logic [7:0]  byte2_i       = 8'h00;
  logic [7:0]  byte3_i       = 8'h00;
  logic [7:0]  operand_i     = 8'h00;
  logic        bit_val_i     = 1'b0;
  logic        bit_latch_i   = 1'b0;
  logic        bit_is_port_i = 1'b0;
  logic        aux_carry_i   = 1'b0;
  wire logic        busy_o;
  wire logic        retire_o;
  wire logic [7:0]  acc_o;
  wire logic        carry_o;
  wire logic [15:0] pc_o;
  wire logic        bit_wr_o;
  wire logic [7:0]  bit_addr_o;
  wire logic        bit_data_o;
  int          failures   = 0;
  int          num_checks = 0;
  logic [7:0]  e_acc      = 8'h00;
  logic        e_c        = 1'b0;
  logic [15:0] e_pc       = 16'h0000;

  blc_exec dut_u (
    .ref_clk_i     (ref_clk_i),
    .reset_n_i     (reset_n_i),
    .start_i       (start_i),
    .opcode_i      (opcode_i),
    .byte2_i       (byte2_i),
    .byte3_i       (byte3_i),
    .operand_i     (operand_i),
    .bit_val_i     (bit_val_i),
    .bit_latch_i   (bit_latch_i),
    .bit_is_port_i (bit_is_port_i),
    .aux_carry_i   (aux_carry_i),
    .busy_o        (busy_o),
    .retire_o      (retire_o),
    .acc_o         (acc_o),
    .carry_o       (carry_o),
    .pc_o          (pc_o),
    .bit_wr_o      (bit_wr_o),
    .bit_addr_o    (bit_addr_o),
    .bit_data_o    (bit_data_o)
  );

  always #12.5 ref_clk_i = ~ref_clk_i;

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // bits = {is_port, latch, val}; expectations e_acc/e_c/e_pc are set by the caller
  task automatic do_op(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
                       input logic [7:0] opnd, input logic [2:0] bits, input logic ac,
                       input int ncyc, input logic wr, input logic wdat);
    int n;
    @(posedge ref_clk_i);
    start_i   <= 1'b1;
    opcode_i  <= op;
    byte2_i   <= b2;
    byte3_i   <= b3;
    operand_i <= opnd;
    {bit_is_port_i, bit_latch_i, bit_val_i} <= bits;
    aux_carry_i <= ac;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    #1;
    n = 1;
    while (retire_o !== 1'b1 && n < 10) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= 10) begin
      failures++;
      tally_and_finish();
    end else begin
      chk(16'(n), 16'(ncyc));
      @(posedge ref_clk_i);
      #1;
      chk({8'h00, acc_o}, {8'h00, e_acc});
      chk({15'h0000, carry_o}, {15'h0000, e_c});
      chk(pc_o, e_pc);
      chk({15'h0000, bit_wr_o}, {15'h0000, wr});
      if (wr) begin
        chk({8'h00, bit_addr_o}, {8'h00, b2});
        chk({15'h0000, bit_data_o}, {15'h0000, wdat});
      end
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_accum();
    e_acc = 8'hff; do_op(8'hf4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_acc = 8'h65; e_c = 1'b1;
    do_op(8'hd4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_acc = 8'h00; do_op(8'he4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_acc = 8'h60; do_op(8'hd4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_c = 1'b0; do_op(8'hc3, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_acc = 8'h00; do_op(8'he4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_acc = 8'h06; do_op(8'hd4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b1, 1, 1'b0, 1'b0);
    e_acc = 8'hf9; do_op(8'hf4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_acc = 8'h59; e_c = 1'b1;
    do_op(8'hd4, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
  endtask

  task automatic t_carry_and();
    // latch disagrees with the bit value: the and must follow the direct bit value
    do_op(8'h82, 8'h20, 8'h00, 8'h00, 3'b101, 1'b0, 2, 1'b0, 1'b0);
    do_op(8'hb0, 8'h21, 8'h00, 8'h00, 3'b000, 1'b0, 2, 1'b0, 1'b0);
    e_c = 1'b0; do_op(8'hb0, 8'h21, 8'h00, 8'h00, 3'b001, 1'b0, 2, 1'b0, 1'b0);
    e_c = 1'b1; do_op(8'hb3, 8'h00, 8'h00, 8'h00, 3'b000, 1'b0, 1, 1'b0, 1'b0);
    e_c = 1'b0; do_op(8'h82, 8'h22, 8'h00, 8'h00, 3'b010, 1'b0, 2, 1'b0, 1'b0);
  endtask

  task automatic t_bit_ops();
    do_op(8'hc2, 8'h45, 8'h00, 8'h00, 3'b001, 1'b0, 2, 1'b1, 1'b0);
    do_op(8'hb2, 8'h90, 8'h00, 8'h00, 3'b110, 1'b0, 2, 1'b1, 1'b0);
    do_op(8'hb2, 8'h31, 8'h00, 8'h00, 3'b001, 1'b0, 2, 1'b1, 1'b0);
    do_op(8'hb2, 8'h32, 8'h00, 8'h00, 3'b010, 1'b0, 2, 1'b1, 1'b1);
  endtask

  task automatic t_compare();
    logic [7:0] ops [6]  = '{8'hb5, 8'hb4, 8'hb6, 8'hb7, 8'hb8, 8'hbf};
    logic [7:0] sec [3]  = '{8'h59, 8'h80, 8'h20};
    logic [7:0] disp [3] = '{8'h05, 8'hf0, 8'h7f};
    logic [7:0] b2;
    logic [7:0] opnd;
    // the first operand is always 59: the accumulator, or operand_i for the other forms
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 3; k++) begin
        b2   = (ops[i] == 8'hb5) ? 8'h33 : sec[k];
        opnd = (ops[i] == 8'hb5) ? sec[k] : ((ops[i] == 8'hb4) ? 8'ha5 : 8'h59);
        e_c  = (8'h59 < sec[k]);
        e_pc = e_pc + 16'h0003 + ((sec[k] != 8'h59) ? {{8{disp[k][7]}}, disp[k]} : 16'h0000);
        do_op(ops[i], b2, disp[k], opnd, 3'b000, 1'b0, 4, 1'b0, 1'b0);
        chk({8'h00, acc_o}, 16'h0059);
      end
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk({8'h00, acc_o}, 16'h0000);
    chk(pc_o, 16'h0000);
    chk({14'h0000, busy_o, carry_o}, 16'h0000);
    t_accum();
    t_carry_and();
    t_bit_ops();
    t_compare();
    tally_and_finish();
  end
endmodule
`default_nettype wire
